/* logic/exc_pkg.sv */
// Constants, register map and vector table for the exception arbitration block
package exc_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_SRC = 13;
    localparam int ADDR_W = 8;
    localparam int CODE_W = 4;
    localparam int STACK_BYTES = 5;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_INT_STATUS_1 = 8'h00;
    localparam logic [7:0] OFS_INT_STATUS_2 = 8'h01;
    localparam logic [7:0] OFS_INT_STATUS_3 = 8'h02;
    localparam logic [7:0] OFS_BREAK_FLAG_CONTROL = 8'h03;
    localparam int BCLR_POS = 7;
    localparam logic [7:0] BCTL_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam int CCR_IMASK_POS = 3;

    // ==========================================================
    // Source indices in priority order (0 is highest)
    localparam logic [3:0] SRC_EXT_PIN = 4'h0;
    localparam logic [3:0] SRC_T1_CH0 = 4'h1;
    localparam logic [3:0] SRC_TWO_WIRE = 4'h7;

    // Codes handed to the CPU for the non-arbitrated entries
    localparam logic [3:0] CODE_TRP = 4'hD;
    localparam logic [3:0] CODE_RESET = 4'hE;

    // ==========================================================
    // Vectors
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRP = 16'hFFFC;
    localparam logic [15:0] VEC_EXT_PIN = 16'hFFFA;
    localparam logic [15:0] VEC_T1_CH0 = 16'hFFF6;
    localparam logic [15:0] VEC_TWO_WIRE = 16'hFFE8;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [15:0] PC_HW_ADJUST = 16'h0001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH = 3'b001,
        ST_VECTOR = 3'b010,
        ST_POP = 3'b011,
        ST_RET_DONE = 3'b100
    } exc_state_type;

    // Vector of an arbitrated hardware source; the timer and serial runs
    // descend by one two-byte vector per step
    function automatic logic [15:0] vec_of(input logic [3:0] code);
        logic [15:0] step;
        step = {12'h000, code};
        if (code == SRC_EXT_PIN) begin
            return VEC_EXT_PIN;
        end else if (code < SRC_TWO_WIRE) begin
            return 16'(VEC_T1_CH0 - VEC_STEP * (step - {12'h000, SRC_T1_CH0}));
        end else begin
            return 16'(VEC_TWO_WIRE - VEC_STEP * (step - {12'h000, SRC_TWO_WIRE}));
        end
    endfunction

endpackage

/* logic/arb_if.sv */
// Request and winner signals between the exception control and its arbiter
`timescale 1ns/1ns
interface arb_if #(parameter int N = 13);
    logic [N-1:0] req;
    logic [N-1:0] en;
    logic mask;
    logic win_valid;
    logic [3:0] win_code;

    modport ctrl (output req, output en, output mask, input win_valid, input win_code);
    modport arb (input req, input en, input mask, output win_valid, output win_code);
endinterface

/* logic/exc_arbiter.sv */
// Fixed-priority arbiter over the maskable hardware sources
`timescale 1ns/1ns
module exc_arbiter
    import exc_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    arb_if.arb bus
);

    logic [N-1:0] eligible;

    // Masked by the global mask bit and by each source enable
    assign eligible = bus.mask ? '0 : (bus.req & bus.en);

    // Lowest index wins, so scan from the top index downward and let the last hit stand
    always_comb begin
        bus.win_valid = 1'b0;
        bus.win_code = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                bus.win_valid = 1'b1;
                bus.win_code = 4'(i);
            end
        end
    end

endmodule

/* logic/exception_arbitration_control.sv */
// Exception control: latching, arbitration, stacking, break and flag protection
// Summary of operation
// - Latch hardware requests; arbitration result is a code selecting the vector.
// - A latched request is kept until any entry, a reset request or a clear-mask instruction.
// - Entry pushes CPU registers to the stack and sets the mask bit.
// - Return-from-interrupt pops the saved registers so the program resumes.
// - Hardware requests never abort an instruction; service starts at its end.
// - At a boundary enter service only if unmasked and source enabled.
// - With several pending, the highest priority is serviced first; a winner latched earlier goes before a later, higher request.
// - Requests pending at return are serviced before the next program instruction.
// - The high index register is never stacked on entry.
// - Software interrupt and break are taken regardless of mask; mask gates hardware requests.
// - Software interrupt stacks PC; hardware interrupt stacks PC minus one.
// - Order: reset, software, external pin, timer 1 then timer 2 sources.
// - Then two-wire unit, serial error, receive, transmit, keyboard, conversion done.
// - First status register shows pin, timer 1, timer 2 channel 0; bits 0,1,3 zero.
// - Second status register shows timer 2, two-wire, serial, keyboard; bit 2 zero.
// - Third status register holds conversion done in bit 0; others zero.
// - Reset sources share top priority and act at once without arbitration.
// - A break request sends the CPU to the software interrupt vector.
// - In break with clear enable low, peripheral flags cannot be cleared.
// - With clear enable high flags clear in break and stay cleared.
// - Two-step clears stay blocked in break; second step after break clears.
`timescale 1ns/1ns
module exception_arbitration_control
    import exc_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    // Clock, reset, enable
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // Register port
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // Peripheral requests and enables, priority order
    input wire logic [N-1:0] SRC_REQ_I,
    input wire logic [N-1:0] SRC_EN_I,
    // CPU core events
    input wire logic INSTR_DONE_I,
    input wire logic TRP_EXEC_I,
    input wire logic RET_EXEC_I,
    input wire logic CLI_I,
    input wire logic SEI_I,
    input wire logic [15:0] PC_I,
    input wire logic [7:0] X_I,
    input wire logic [7:0] A_I,
    input wire logic [7:0] CCR_I,
    input wire logic [7:0] STK_RDATA_I,
    // Break unit and reset sources
    input wire logic BREAK_REQ_I,
    input wire logic RESET_REQ_I,
    // Vector hand-off to the CPU
    output logic INT_START_O,
    output logic VEC_VALID_O,
    output logic [15:0] VEC_ADDR_O,
    output logic [CODE_W-1:0] VEC_CODE_O,
    output logic FETCH_NEXT_O,
    // Stack traffic
    output logic STK_PUSH_O,
    output logic [7:0] STK_DATA_O,
    output logic STK_POP_O,
    output logic RET_DONE_O,
    // Mode outputs
    output logic I_MASK_O,
    output logic BREAK_STATE_O,
    output logic FLAG_CLR_ALLOW_O
);

    // ==========================================================
    // Arbiter
    arb_if #(.N(N)) arb_bus ();

    exc_arbiter #(.N(N)) u_arb (
        .bus(arb_bus.arb)
    );

    logic i_bit_r;

    assign arb_bus.req = SRC_REQ_I;
    assign arb_bus.en = SRC_EN_I;
    assign arb_bus.mask = i_bit_r;

    // ==========================================================
    // State
    exc_state_type state_r;
    logic [2:0] cnt_r;
    logic latch_valid_r;
    logic [3:0] latch_code_r;
    logic break_state_r;
    logic [7:0] bctl_r;
    logic [15:0] ret_pc_r;
    logic [7:0] save_x_r;
    logic [7:0] save_a_r;
    logic [7:0] save_ccr_r;
    logic [15:0] vec_addr_r;
    logic [3:0] vec_code_r;
    logic [7:0] sts1_nxt;
    logic [7:0] sts2_nxt;
    logic [7:0] sts3_nxt;
    logic take_break;
    logic take_trp;
    logic take_hw;
    logic [3:0] hw_code;
    logic entry;

    // Only sampled at an instruction boundary, never mid-instruction
    assign take_break = (state_r == ST_IDLE) && INSTR_DONE_I && BREAK_REQ_I;
    assign take_trp = (state_r == ST_IDLE) && INSTR_DONE_I && !BREAK_REQ_I && TRP_EXEC_I;
    // Unmasked, enabled hardware request only
    assign take_hw = (state_r == ST_IDLE) && INSTR_DONE_I && !BREAK_REQ_I && !TRP_EXEC_I
        && !i_bit_r && (latch_valid_r || arb_bus.win_valid);
    // A latched winner is never displaced by a later request
    assign hw_code = latch_valid_r ? latch_code_r : arb_bus.win_code;
    assign entry = take_break || take_trp || take_hw;

    // ==========================================================
    // Request latch
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            latch_valid_r <= 1'b0;
            latch_code_r <= 4'h0;
        end else if (CE_I) begin
            if (RESET_REQ_I || entry || CLI_I) begin
                latch_valid_r <= 1'b0;
            end else if (!latch_valid_r && arb_bus.win_valid) begin
                latch_valid_r <= 1'b1;
                latch_code_r <= arb_bus.win_code;
            end
        end
    end

    // ==========================================================
    // Global mask bit
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            i_bit_r <= 1'b1;
        end else if (CE_I) begin
            if (RESET_REQ_I) begin
                i_bit_r <= 1'b1;
            end else if (entry) begin
                i_bit_r <= 1'b1;
            end else if (state_r == ST_POP && cnt_r == 3'd2) begin
                // Condition codes are the first byte popped
                i_bit_r <= STK_RDATA_I[CCR_IMASK_POS];
            end else if (SEI_I) begin
                i_bit_r <= 1'b1;
            end else if (CLI_I) begin
                i_bit_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'd0;
        end else if (CE_I) begin
            if (RESET_REQ_I) begin
                state_r <= ST_IDLE;
                cnt_r <= 3'd0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        cnt_r <= 3'd0;
                        if (entry) begin
                            state_r <= ST_PUSH;
                        end else if (RET_EXEC_I) begin
                            state_r <= ST_POP;
                        end
                    end
                    ST_PUSH: begin
                        if (cnt_r == 3'(STACK_BYTES - 1)) begin
                            state_r <= ST_VECTOR;
                            cnt_r <= 3'd0;
                        end else begin
                            cnt_r <= cnt_r + 3'd1;
                        end
                    end
                    ST_VECTOR: begin
                        state_r <= ST_IDLE;
                    end
                    ST_POP: begin
                        if (cnt_r == 3'(STACK_BYTES - 1)) begin
                            state_r <= ST_RET_DONE;
                            cnt_r <= 3'd0;
                        end else begin
                            cnt_r <= cnt_r + 3'd1;
                        end
                    end
                    ST_RET_DONE: begin
                        // Next boundary rechecks pending requests first
                        state_r <= ST_IDLE;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Entry capture: return address, registers, vector
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            ret_pc_r <= 16'h0000;
            save_x_r <= 8'h00;
            save_a_r <= 8'h00;
            save_ccr_r <= 8'h00;
            vec_addr_r <= VEC_RESET;
            vec_code_r <= CODE_RESET;
        end else if (CE_I) begin
            if (entry) begin
                save_x_r <= X_I;
                save_a_r <= A_I;
                save_ccr_r <= CCR_I;
                if (take_hw) begin
                    ret_pc_r <= 16'(PC_I - PC_HW_ADJUST);
                    vec_addr_r <= vec_of(hw_code);
                    vec_code_r <= hw_code;
                end else begin
                    // Break and software interrupt share the trap vector
                    ret_pc_r <= PC_I;
                    vec_addr_r <= VEC_TRP;
                    vec_code_r <= CODE_TRP;
                end
            end
        end
    end

    // ==========================================================
    // Stack and vector outputs
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            STK_PUSH_O <= 1'b0;
            STK_DATA_O <= 8'h00;
            STK_POP_O <= 1'b0;
            RET_DONE_O <= 1'b0;
            INT_START_O <= 1'b0;
            VEC_VALID_O <= 1'b0;
            VEC_ADDR_O <= VEC_RESET;
            VEC_CODE_O <= CODE_RESET;
            FETCH_NEXT_O <= 1'b0;
        end else if (CE_I) begin
            STK_PUSH_O <= (state_r == ST_PUSH) && !RESET_REQ_I;
            STK_POP_O <= (state_r == ST_POP) && !RESET_REQ_I;
            RET_DONE_O <= (state_r == ST_RET_DONE) && !RESET_REQ_I;
            INT_START_O <= entry && !RESET_REQ_I;
            FETCH_NEXT_O <= (state_r == ST_IDLE) && INSTR_DONE_I && !entry
                && !RET_EXEC_I && !RESET_REQ_I;
            // High index register deliberately absent from the push order
            case (cnt_r)
                3'd0: STK_DATA_O <= ret_pc_r[7:0];
                3'd1: STK_DATA_O <= ret_pc_r[15:8];
                3'd2: STK_DATA_O <= save_x_r;
                3'd3: STK_DATA_O <= save_a_r;
                default: STK_DATA_O <= save_ccr_r;
            endcase
            if (RESET_REQ_I) begin
                VEC_VALID_O <= 1'b1;
                VEC_ADDR_O <= VEC_RESET;
                VEC_CODE_O <= CODE_RESET;
            end else if (state_r == ST_VECTOR) begin
                VEC_VALID_O <= 1'b1;
                VEC_ADDR_O <= vec_addr_r;
                VEC_CODE_O <= vec_code_r;
            end else begin
                VEC_VALID_O <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Break state and flag protection
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            break_state_r <= 1'b0;
        end else if (CE_I) begin
            if (RESET_REQ_I) begin
                break_state_r <= 1'b0;
            end else if (take_break) begin
                break_state_r <= 1'b1;
            end else if (state_r == ST_RET_DONE) begin
                break_state_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            I_MASK_O <= 1'b1;
            BREAK_STATE_O <= 1'b0;
            FLAG_CLR_ALLOW_O <= 1'b1;
        end else if (CE_I) begin
            I_MASK_O <= i_bit_r;
            BREAK_STATE_O <= break_state_r;
            // Peripherals keep any first-step arming; only the clear is held off,
            // so the second step after break still completes
            FLAG_CLR_ALLOW_O <= !break_state_r || bctl_r[BCLR_POS];
        end
    end

    // ==========================================================
    // Register file
    always_comb begin
        sts1_nxt = {SRC_REQ_I[4:1], 1'b0, SRC_REQ_I[0], 2'b00};
        sts2_nxt = {SRC_REQ_I[11:7], 1'b0, SRC_REQ_I[6:5]};
        sts3_nxt = {7'h00, SRC_REQ_I[12]};
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            bctl_r <= BCTL_RESET;
        end else if (CE_I) begin
            // Status registers have no write path
            if (REG_WR_I && REG_ADDR_I == OFS_BREAK_FLAG_CONTROL) begin
                bctl_r <= {REG_WDATA_I[BCLR_POS], 7'h00};
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= RDATA_RESET;
        end else if (CE_I) begin
            if (!REG_RD_I) begin
                REG_RDATA_O <= RDATA_RESET;
            end else if (REG_ADDR_I == OFS_INT_STATUS_1) begin
                REG_RDATA_O <= sts1_nxt;
            end else if (REG_ADDR_I == OFS_INT_STATUS_2) begin
                REG_RDATA_O <= sts2_nxt;
            end else if (REG_ADDR_I == OFS_INT_STATUS_3) begin
                REG_RDATA_O <= sts3_nxt;
            end else if (REG_ADDR_I == OFS_BREAK_FLAG_CONTROL) begin
                REG_RDATA_O <= bctl_r;
            end else begin
                REG_RDATA_O <= RDATA_RESET;
            end
        end
    end

endmodule

/* testbench/cpu_stack_model.sv */
// Stack memory of the CPU core, answering push and pop traffic
`timescale 1ns/1ns
module cpu_stack_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Stack traffic
    input wire logic push_i,
    input wire logic [7:0] data_i,
    input wire logic pop_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem[$];
    // Released bus toggles so a stale byte never passes for an answer
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem.delete();
            rdata_o <= 8'h00;
        end else if (push_i) begin
            mem.push_back(data_i);
        end else if (pop_i) begin
            rdata_o <= mem.pop_back();
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
endmodule

/* testbench/exception_sva.sv */
// Assertion checker for the exception arbitration block
`timescale 1ns/1ns
module exception_sva
    import exc_pkg::*;
(
    // Clock and controls
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_RD_I,
    input wire logic INSTR_DONE_I,
    input wire logic TRP_EXEC_I,
    input wire logic CLI_I,
    input wire logic [15:0] PC_I,
    input wire logic BREAK_REQ_I,
    input wire logic RESET_REQ_I,
    // Outputs
    input wire logic [7:0] REG_RDATA_O,
    input wire logic INT_START_O,
    input wire logic VEC_VALID_O,
    input wire logic [15:0] VEC_ADDR_O,
    input wire logic [CODE_W-1:0] VEC_CODE_O,
    input wire logic STK_PUSH_O,
    input wire logic [7:0] STK_DATA_O,
    input wire logic STK_POP_O,
    input wire logic RET_DONE_O,
    input wire logic I_MASK_O,
    input wire logic BREAK_STATE_O,
    input wire logic FLAG_CLR_ALLOW_O
);
    default clocking dc @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    // ====
    // Helpers
    logic [7:0] rsvd_r;
    logic [15:0] hw_vec;
    assign hw_vec = VEC_CODE_O == 4'h0 ? VEC_EXT_PIN :
        (VEC_CODE_O < SRC_TWO_WIRE ? 16'hFFF8 : 16'hFFF6) - {11'h000, VEC_CODE_O, 1'b0};
    // Bits that must read zero at the address just read
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rsvd_r <= 8'h00;
        end else begin
            rsvd_r <= REG_ADDR_I == OFS_INT_STATUS_1 ? 8'h0B : REG_ADDR_I == OFS_INT_STATUS_2 ?
                8'h04 : REG_ADDR_I == OFS_INT_STATUS_3 ? 8'hFE : 8'h7F;
        end
    end
    // ====
    // Properties
    property p_entry;
        INT_START_O |=> STK_PUSH_O [*5] ##1 VEC_VALID_O;
    endproperty
    a_entry: assert property (p_entry) else $error("entry sequence broken");
    property p_pc;
        INT_START_O && !$past(TRP_EXEC_I) && !$past(BREAK_REQ_I)
            |=> STK_DATA_O == 8'($past(PC_I, 2) - 16'h0001);
    endproperty
    a_pc: assert property (p_pc) else $error("stacked pc wrong");
    property p_trp;
        VEC_VALID_O && VEC_CODE_O == CODE_TRP |-> VEC_ADDR_O == VEC_TRP;
    endproperty
    a_trp: assert property (p_trp) else $error("trap vector wrong");
    property p_hwvec;
        VEC_VALID_O && VEC_CODE_O < CODE_TRP |-> VEC_ADDR_O == hw_vec;
    endproperty
    a_hwvec: assert property (p_hwvec) else $error("source vector wrong");
    property p_reset;
        CE_I && RESET_REQ_I |=> VEC_VALID_O && VEC_ADDR_O == VEC_RESET ##1 I_MASK_O;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not immediate");
    property p_pop;
        STK_POP_O && !$past(STK_POP_O) |-> STK_POP_O [*5] ##1 RET_DONE_O;
    endproperty
    a_pop: assert property (p_pop) else $error("return sequence broken");
    property p_masked;
        CE_I && INSTR_DONE_I && I_MASK_O && !CLI_I && !TRP_EXEC_I && !BREAK_REQ_I
            |=> !INT_START_O;
    endproperty
    a_masked: assert property (p_masked) else $error("masked entry");
    property p_rsvd;
        CE_I && REG_RD_I |=> (REG_RDATA_O & rsvd_r) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_flag;
        CE_I && !BREAK_STATE_O |-> FLAG_CLR_ALLOW_O;
    endproperty
    a_flag: assert property (p_flag) else $error("flags blocked outside break");
endmodule
bind exception_arbitration_control exception_sva u_sva (
    .MCLK_I, .RST_I, .CE_I, .REG_ADDR_I, .REG_RD_I, .INSTR_DONE_I, .TRP_EXEC_I, .CLI_I,
    .PC_I, .BREAK_REQ_I, .RESET_REQ_I, .REG_RDATA_O, .INT_START_O, .VEC_VALID_O,
    .VEC_ADDR_O, .VEC_CODE_O, .STK_PUSH_O, .STK_DATA_O, .STK_POP_O, .RET_DONE_O,
    .I_MASK_O, .BREAK_STATE_O, .FLAG_CLR_ALLOW_O
);

/* testbench/tb.sv */
// Self-checking bench for the exception arbitration block
`timescale 1ns/1ns
module tb;
    import exc_pkg::*;
    logic MCLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic CE_I = 1'b1;
    logic REG_WR_I = 1'b0, REG_RD_I = 1'b0, INSTR_DONE_I = 1'b0, TRP_EXEC_I = 1'b0;
    logic RET_EXEC_I = 1'b0, CLI_I = 1'b0, SEI_I = 1'b0, BREAK_REQ_I = 1'b0, RESET_REQ_I = 1'b0;
    logic [7:0] REG_ADDR_I = 8'h00, REG_WDATA_I = 8'h00, X_I = 8'h00, A_I = 8'h00, CCR_I = 8'h00;
    logic [12:0] SRC_REQ_I = 13'h0000, SRC_EN_I = 13'h1FFF, r, e;
    logic [15:0] PC_I = 16'h0000, VEC_ADDR_O;
    logic [7:0] STK_RDATA_I, REG_RDATA_O, STK_DATA_O, lfsr_r = 8'h36, ccr_last, pushed[$];
    logic [3:0] VEC_CODE_O;
    logic INT_START_O, VEC_VALID_O, FETCH_NEXT_O, STK_PUSH_O, STK_POP_O, RET_DONE_O;
    logic I_MASK_O, BREAK_STATE_O, FLAG_CLR_ALLOW_O;
    int n_errors = 0, n_compared = 0, i;
    exception_arbitration_control #(.N(NUM_SRC)) dut (
        .MCLK_I, .RST_I, .CE_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
        .SRC_REQ_I, .SRC_EN_I, .INSTR_DONE_I, .TRP_EXEC_I, .RET_EXEC_I, .CLI_I, .SEI_I, .PC_I,
        .X_I, .A_I, .CCR_I, .STK_RDATA_I, .BREAK_REQ_I, .RESET_REQ_I, .INT_START_O,
        .VEC_VALID_O, .VEC_ADDR_O, .VEC_CODE_O, .FETCH_NEXT_O, .STK_PUSH_O, .STK_DATA_O,
        .STK_POP_O, .RET_DONE_O, .I_MASK_O, .BREAK_STATE_O, .FLAG_CLR_ALLOW_O
    );
    cpu_stack_model cpu (.clk_i(MCLK_I), .rst_i(RST_I), .push_i(STK_PUSH_O),
        .data_i(STK_DATA_O), .pop_i(STK_POP_O), .rdata_o(STK_RDATA_I));
    always #4 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        if (STK_PUSH_O === 1'b1) begin
            pushed.push_back(STK_DATA_O);
        end
    end
    // ====
    // Reference model
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction
    function automatic logic [15:0] vec(input int c);
        return 16'(c == 13 ? 32'hFFFC : c == 0 ? 32'hFFFA :
            c < 7 ? 32'hFFF8 - 2 * c : 32'hFFF6 - 2 * c);
    endfunction
    function automatic int win(input logic [12:0] q, input logic [12:0] m);
        for (int k = 0; k < 13; k++) begin
            if (q[k] && m[k]) begin
                return k;
            end
        end
        return -1;
    endfunction
    // ====
    // Bus and CPU tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge MCLK_I);
        REG_WR_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge MCLK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge MCLK_I);
        REG_RD_I <= 1'b0;
        #1;
        check("read data", 16'(REG_RDATA_O), 16'(x));
    endtask
    task automatic wait_for(ref logic s);
        for (int k = 0; k < 20 && s !== 1'b1; k++) begin
            @(posedge MCLK_I);
            #1;
        end
    endtask
    task automatic enter(input logic trp, input int code);
        logic [15:0] pc;
        logic [7:0] st[5];
        pc = {rnd(), rnd()};
        st = '{8'h00, 8'h00, rnd(), rnd(), rnd() & 8'hF7};
        ccr_last = st[4];
        pushed.delete();
        @(posedge MCLK_I);
        INSTR_DONE_I <= 1'b1;
        TRP_EXEC_I <= trp;
        PC_I <= pc;
        X_I <= st[2];
        A_I <= st[3];
        CCR_I <= st[4];
        @(posedge MCLK_I);
        INSTR_DONE_I <= 1'b0;
        TRP_EXEC_I <= 1'b0;
        wait_for(VEC_VALID_O);
        check("code", 16'(VEC_CODE_O), 16'(code));
        check("vector", VEC_ADDR_O, vec(code));
        check("mask", 16'(I_MASK_O), 16'h0001);
        check("push count", 16'(pushed.size()), 16'h0005);
        pc = code == 13 ? pc : pc - 16'h0001;
        st[0] = pc[7:0];
        st[1] = pc[15:8];
        for (int k = 0; k < 5; k++) begin
            check("stacked byte", 16'(pushed[k]), 16'(st[k]));
        end
    endtask
    task automatic ret();
        @(posedge MCLK_I);
        RET_EXEC_I <= 1'b1;
        @(posedge MCLK_I);
        RET_EXEC_I <= 1'b0;
        wait_for(RET_DONE_O);
        check("return done", 16'(RET_DONE_O), 16'h0001);
        check("mask restored", 16'(I_MASK_O), 16'(ccr_last[3]));
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ====
    // Scenarios
    initial begin
        repeat (20) @(posedge MCLK_I);
        RST_I <= 1'b0;
        @(posedge MCLK_I);
        #1;
        check("reset vector", VEC_ADDR_O, VEC_RESET);
        for (i = 0; i < 6; i++) begin
            r = 13'({rnd(), rnd()});
            SRC_REQ_I <= r;
            wr(OFS_INT_STATUS_1 + 8'(i % 3), 8'hFF);
            rd(OFS_INT_STATUS_1, {r[4:1], 1'b0, r[0], 2'b00});
            rd(OFS_INT_STATUS_2, {r[11:7], 1'b0, r[6:5]});
            rd(OFS_INT_STATUS_3, {7'h00, r[12]});
        end
        rd(OFS_BREAK_FLAG_CONTROL, BCTL_RESET);
        wr(OFS_BREAK_FLAG_CONTROL, 8'hFF);
        rd(OFS_BREAK_FLAG_CONTROL, 8'h80);
        wr(OFS_BREAK_FLAG_CONTROL, 8'h00);
        rd(8'hA5, 8'h00);
        // Mask still set from reset: boundary must fall through
        @(posedge MCLK_I);
        INSTR_DONE_I <= 1'b1;
        @(posedge MCLK_I);
        INSTR_DONE_I <= 1'b0;
        #1;
        check("fetch next", 16'({FETCH_NEXT_O, INT_START_O}), 16'h0002);
        enter(1'b1, 13);
        for (i = 12; i >= 0; i--) begin
            r = 13'({rnd(), rnd()}) & (13'h1FFF << i) | (13'h0001 << i);
            e = 13'h1FFF;
            if (i > 0) begin
                r[i - 1] = 1'b1;
                e[i - 1] = 1'b0;
            end
            SRC_REQ_I <= r;
            SRC_EN_I <= e;
            ret();
            enter(1'b0, win(r, e));
        end
        ret();
        BREAK_REQ_I <= 1'b1;
        enter(1'b0, 13);
        BREAK_REQ_I <= 1'b0;
        check("break", 16'({BREAK_STATE_O, FLAG_CLR_ALLOW_O}), 16'h0002);
        wr(OFS_BREAK_FLAG_CONTROL, 8'h80);
        @(posedge MCLK_I);
        #1;
        check("clear allowed", 16'(FLAG_CLR_ALLOW_O), 16'h0001);
        ret();
        wr(OFS_BREAK_FLAG_CONTROL, 8'h00);
        check("break left", 16'(BREAK_STATE_O), 16'h0000);
        @(posedge MCLK_I);
        RESET_REQ_I <= 1'b1;
        @(posedge MCLK_I);
        @(posedge MCLK_I);
        RESET_REQ_I <= 1'b0;
        #1;
        check("reset request", VEC_ADDR_O, VEC_RESET);
        check("reset state", 16'({VEC_VALID_O, I_MASK_O}), 16'h0003);
        wrap_up();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge MCLK_I);
        n_errors++;
        wrap_up();
    end
endmodule
